// *** touch_scan_pkg.sv ***
package touch_scan_pkg;

  // ----------------------------------------------------------------
  // Structure and counter limits
  // ----------------------------------------------------------------
  localparam int NUM_MODULES = 3;
  localparam logic [4:0] PRESCALE_LAST = 5'h1f;
  localparam logic [4:0] PRESCALE_ZERO = 5'h00;
  localparam logic [7:0] SLOT_LAST = 8'hff;
  localparam logic [15:0] COUNT_LAST = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [1:0] SCAN_LAST_SLOT = 2'h3;
  localparam logic [3:0][2:0] DIV_MASK = {3'h7, 3'h3, 3'h1, 3'h0};

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PRELOAD = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_CLKSEL = 8'h08;
  localparam logic [7:0] ADDR_FUNC_LO = 8'h0c;
  localparam logic [7:0] ADDR_FUNC_HI = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_KEY_BASE = 8'h20;
  localparam logic [7:0] KEY_STRIDE = 8'h08;
  localparam logic [7:0] KEY_HI_OFS = 8'h04;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_OWNER = 7;
  localparam int CTL_OVF = 6;
  localparam int CTL_START = 5;
  localparam int CTL_KEY_OVF = 4;
  localparam int CTL_FUNC_OVF = 3;
  localparam int CTL_MODE = 1;
  localparam int CTL_BUSY = 0;
  localparam int CLK_SLOT_COUNTER_SELECT = 4;
  localparam int CLK_DIV_HI = 3;
  localparam int CLK_DIV_LO = 2;
  localparam int IRQ_MODULE = 0;
  localparam int IRQ_KEY = 1;
  localparam int IRQ_FUNC = 2;
  localparam int IRQ_W = 3;
  localparam logic [7:0] CLKSEL_RESET = 8'h03;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_MANUAL = 2'b01,
    SCAN_AUTO = 2'b10
  } scan_state_t;

  typedef struct packed {
    logic run;
    logic clear;
    logic reload;
  } slot_ctl_t;

  typedef struct packed {
    logic run;
    logic clear;
  } count_ctl_t;

endpackage : touch_scan_pkg

// *** touch_slot_timer.sv ***
`timescale 1ns/1ps
module touch_slot_timer (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic slot_clk,
  input wire touch_scan_pkg::slot_ctl_t ctl,
  input wire logic [7:0] preload,
  output logic ovf
);

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [4:0] prescale;
    logic [7:0] slot;
    logic ovf;
  } timer_state_t;

  timer_state_t q;
  timer_state_t next_q;
  logic tick;

  // Slot clock edge counts once stages two and three agree
  assign tick = (q.sync[1] == q.sync[2]) & q.sync[2] & ~q.level;

  always_comb begin
    next_q = q;
    next_q.sync = {q.sync[1:0], slot_clk};
    next_q.ovf = 1'b0;
    if (q.sync[1] == q.sync[2]) begin
      next_q.level = q.sync[2];
    end
    if (ctl.reload) begin
      next_q.slot = preload;
      next_q.prescale = touch_scan_pkg::PRESCALE_ZERO;
    end else if (ctl.clear) begin
      next_q.prescale = touch_scan_pkg::PRESCALE_ZERO;
    end else if (ctl.run && tick) begin
      next_q.prescale = q.prescale + 5'h01;
      if (q.prescale == touch_scan_pkg::PRESCALE_LAST) begin
        next_q.slot = q.slot + 8'h01;
        next_q.ovf = (q.slot == touch_scan_pkg::SLOT_LAST);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign ovf = q.ovf;

  slot_step_a: assert property (@(posedge ref_clk) disable iff (srst)
    (q.slot != $past(q.slot)) && !$past(ctl.reload) |-> $past(q.prescale) == touch_scan_pkg::PRESCALE_LAST)
    else $error("Slot counter stepped before 32 prescale cycles");
  slot_reload_a: assert property (@(posedge ref_clk) disable iff (srst)
    ctl.reload |=> (q.slot == $past(preload)) && (q.prescale == touch_scan_pkg::PRESCALE_ZERO))
    else $error("Slot counter not loaded from preload");

endmodule : touch_slot_timer

// *** touch_key_counter.sv ***
`timescale 1ns/1ps
module touch_key_counter (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic osc_in,
  input wire touch_scan_pkg::count_ctl_t ctl,
  output logic [15:0] count,
  output logic ovf
);

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [15:0] count;
    logic ovf;
  } key_state_t;

  key_state_t q;
  key_state_t next_q;
  logic edge_seen;

  // Oscillator is asynchronous: three stages, counted once two and three agree
  assign edge_seen = (q.sync[1] == q.sync[2]) & q.sync[2] & ~q.level;

  always_comb begin
    next_q = q;
    next_q.sync = {q.sync[1:0], osc_in};
    next_q.ovf = 1'b0;
    if (q.sync[1] == q.sync[2]) begin
      next_q.level = q.sync[2];
    end
    if (ctl.clear) begin
      next_q.count = touch_scan_pkg::COUNT_ZERO;
    end else if (ctl.run && edge_seen) begin
      next_q.count = q.count + 16'h0001;
      next_q.ovf = (q.count == touch_scan_pkg::COUNT_LAST);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign count = q.count;
  assign ovf = q.ovf;

endmodule : touch_key_counter

// *** touch_key_scan_timing.sv ***
`timescale 1ns/1ps
module touch_key_scan_timing (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic slot_clk,
  input wire logic [touch_scan_pkg::NUM_MODULES-1:0] key_osc,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic mem_to_scanner,
  output logic osc_enable
);

  localparam int NM = touch_scan_pkg::NUM_MODULES;

  typedef struct packed {
    logic [7:0] preload;
    logic owner;
    logic ovf_flag;
    logic start;
    logic key_ovf;
    logic func_ovf;
    logic mode;
    logic busy;
    logic [7:0] clksel;
    touch_scan_pkg::scan_state_t state;
    logic [1:0] slot_idx;
    logic [NM-1:0] done;
    logic auto_prio;
    logic mem_scanner;
    logic osc_on;
    logic [2:0] div;
    logic [15:0] func_cnt;
    logic [touch_scan_pkg::IRQ_W-1:0] irq_stat;
    logic [touch_scan_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scan_regs_t;

  scan_regs_t q;
  scan_regs_t next_q;

  logic [NM-1:0] mod_ovf;
  logic [NM-1:0] key_ovf_ev;
  logic [NM-1:0][15:0] key_count;
  touch_scan_pkg::slot_ctl_t slot_ctl;
  touch_scan_pkg::count_ctl_t key_ctl;
  logic wr_fire;
  logic wr_ctl;
  logic start_rise;
  logic ovf_sel;
  logic scan_event;
  logic mid_event;
  logic end_event;
  logic func_tick;
  logic [2:0] div_mask;
  logic [7:0] wbyte;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // ----------------------------------------------------------------
  // Per-module timers and counters
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NM; gi++) begin : g_mod
      touch_slot_timer u_timer (
        .ref_clk(ref_clk),
        .srst(srst),
        .slot_clk(slot_clk),
        .ctl(slot_ctl),
        .preload(q.preload),
        .ovf(mod_ovf[gi])
      );
      touch_key_counter u_count (
        .ref_clk(ref_clk),
        .srst(srst),
        .osc_in(key_osc[gi]),
        .ctl(key_ctl),
        .count(key_count[gi]),
        .ovf(key_ovf_ev[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Scan events
  // ----------------------------------------------------------------
  assign wr_fire = q.aw_have & q.w_have & ~q.bvalid;
  assign wbyte = q.wdata[7:0];
  assign wr_ctl = wr_fire & q.wstrb[0] & (q.aw_addr == touch_scan_pkg::ADDR_CONTROL);
  assign start_rise = wr_ctl & wbyte[touch_scan_pkg::CTL_START] & ~q.start;
  // Separate counters all overflow together when fed alike; with slot counter select clear all are awaited, when set module 0 alone ends the slot
  assign ovf_sel = q.clksel[touch_scan_pkg::CLK_SLOT_COUNTER_SELECT] ? mod_ovf[0] : &(q.done | mod_ovf);
  assign scan_event = q.busy & ovf_sel;
  assign mid_event = scan_event & (q.state == touch_scan_pkg::SCAN_AUTO)
                     & (q.slot_idx != touch_scan_pkg::SCAN_LAST_SLOT);
  assign end_event = scan_event & ~mid_event;
  assign div_mask = touch_scan_pkg::DIV_MASK[q.clksel[touch_scan_pkg::CLK_DIV_HI:touch_scan_pkg::CLK_DIV_LO]];
  assign func_tick = q.busy & ((q.div & div_mask) == div_mask);

  always_comb begin
    slot_ctl.run = q.busy;
    slot_ctl.reload = start_rise | mid_event;
    slot_ctl.clear = ~q.start;
    key_ctl.run = q.busy;
    key_ctl.clear = ~q.start | mid_event;
  end

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      touch_scan_pkg::ADDR_PRELOAD: rd_word[7:0] = q.preload;
      touch_scan_pkg::ADDR_CONTROL: rd_word[7:0] = {q.owner, q.ovf_flag, q.start, q.key_ovf,
                                                    q.func_ovf, 1'b0, q.mode, q.busy};
      touch_scan_pkg::ADDR_CLKSEL: rd_word[7:0] = q.clksel;
      touch_scan_pkg::ADDR_FUNC_LO: rd_word[7:0] = q.func_cnt[7:0];
      touch_scan_pkg::ADDR_FUNC_HI: rd_word[7:0] = q.func_cnt[15:8];
      touch_scan_pkg::ADDR_IRQ_STAT: rd_word[touch_scan_pkg::IRQ_W-1:0] = q.irq_stat;
      touch_scan_pkg::ADDR_IRQ_MASK: rd_word[touch_scan_pkg::IRQ_W-1:0] = q.irq_mask;
      default: rd_hit = 1'b0;
    endcase
    for (int i = 0; i < NM; i++) begin
      if (s_axi_araddr == 8'(touch_scan_pkg::ADDR_KEY_BASE + 8'(i) * touch_scan_pkg::KEY_STRIDE)) begin
        rd_word[7:0] = key_count[i][7:0];
        rd_hit = 1'b1;
      end
      if (s_axi_araddr == 8'(touch_scan_pkg::ADDR_KEY_BASE + 8'(i) * touch_scan_pkg::KEY_STRIDE
                             + touch_scan_pkg::KEY_HI_OFS)) begin
        rd_word[7:0] = key_count[i][15:8];
        rd_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    wr_hit = 1'b1;

    // Bus channels
    if (s_axi_awvalid && q.awready) begin
      next_q.aw_have = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.w_have = 1'b1;
      next_q.wdata = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = rd_word;
      next_q.rresp = rd_hit ? touch_scan_pkg::RESP_OKAY : touch_scan_pkg::RESP_SLVERR;
    end

    // Software writes
    if (wr_fire) begin
      next_q.aw_have = 1'b0;
      next_q.w_have = 1'b0;
      next_q.bvalid = 1'b1;
      case (q.aw_addr)
        touch_scan_pkg::ADDR_PRELOAD: if (q.wstrb[0]) next_q.preload = wbyte;
        touch_scan_pkg::ADDR_CONTROL: if (q.wstrb[0]) begin
          next_q.owner = wbyte[touch_scan_pkg::CTL_OWNER];
          next_q.ovf_flag = wbyte[touch_scan_pkg::CTL_OVF];
          next_q.start = wbyte[touch_scan_pkg::CTL_START];
          next_q.key_ovf = wbyte[touch_scan_pkg::CTL_KEY_OVF];
          next_q.func_ovf = wbyte[touch_scan_pkg::CTL_FUNC_OVF];
          next_q.mode = wbyte[touch_scan_pkg::CTL_MODE];
        end
        touch_scan_pkg::ADDR_CLKSEL: if (q.wstrb[0]) next_q.clksel = wbyte;
        touch_scan_pkg::ADDR_IRQ_STAT: if (q.wstrb[0]) begin
          next_q.irq_stat = q.irq_stat & ~wbyte[touch_scan_pkg::IRQ_W-1:0];
        end
        touch_scan_pkg::ADDR_IRQ_MASK: if (q.wstrb[0]) begin
          next_q.irq_mask = wbyte[touch_scan_pkg::IRQ_W-1:0];
        end
        default: wr_hit = (q.aw_addr >= touch_scan_pkg::ADDR_KEY_BASE)
                          && (q.aw_addr < 8'(touch_scan_pkg::ADDR_KEY_BASE + 8'(NM) * touch_scan_pkg::KEY_STRIDE));
      endcase
      next_q.bresp = wr_hit ? touch_scan_pkg::RESP_OKAY : touch_scan_pkg::RESP_SLVERR;
    end

    // Clearing start stops the scan and zeroes the running counts
    if (!next_q.start) begin
      next_q.busy = 1'b0;
      next_q.state = touch_scan_pkg::SCAN_IDLE;
      next_q.auto_prio = 1'b0;
    end

    // Function counter, clocked from the divided system clock
    next_q.div = q.busy ? q.div + 3'h1 : 3'h0;
    if (!q.start || mid_event) begin
      next_q.func_cnt = touch_scan_pkg::COUNT_ZERO;
    end else if (func_tick) begin
      next_q.func_cnt = q.func_cnt + 16'h0001;
      if (q.func_cnt == touch_scan_pkg::COUNT_LAST) begin
        next_q.func_ovf = 1'b1;
        next_q.irq_stat[touch_scan_pkg::IRQ_FUNC] = 1'b1;
      end
    end
    if (|key_ovf_ev) begin
      next_q.key_ovf = 1'b1;
      next_q.irq_stat[touch_scan_pkg::IRQ_KEY] = 1'b1;
    end

    // Scan sequencing
    if (q.busy && !ovf_sel) begin
      next_q.done = q.done | mod_ovf;
    end
    if (start_rise) begin
      next_q.busy = 1'b1;
      next_q.slot_idx = 2'h0;
      next_q.done = '0;
      if (wbyte[touch_scan_pkg::CTL_MODE]) begin
        next_q.state = touch_scan_pkg::SCAN_MANUAL;
      end else begin
        next_q.state = touch_scan_pkg::SCAN_AUTO;
        next_q.auto_prio = 1'b1;
      end
    end else if (mid_event) begin
      next_q.slot_idx = q.slot_idx + 2'h1;
      next_q.done = '0;
    end else if (end_event) begin
      next_q.ovf_flag = 1'b1;
      next_q.irq_stat[touch_scan_pkg::IRQ_MODULE] = 1'b1;
      next_q.busy = 1'b0;
      next_q.state = touch_scan_pkg::SCAN_IDLE;
      next_q.auto_prio = 1'b0;
      next_q.done = '0;
    end

    // Outputs
    next_q.mem_scanner = next_q.auto_prio | next_q.owner;
    next_q.osc_on = next_q.busy;
    next_q.irq = |(next_q.irq_stat & next_q.irq_mask);
    next_q.awready = ~next_q.aw_have & ~next_q.bvalid;
    next_q.wready = ~next_q.w_have & ~next_q.bvalid;
    next_q.arready = ~next_q.rvalid;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
      q.clksel <= touch_scan_pkg::CLKSEL_RESET;
      q.state <= touch_scan_pkg::SCAN_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign irq = q.irq;
  assign mem_to_scanner = q.mem_scanner;
  assign osc_enable = q.osc_on;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  auto_priority_a: assert property (@(posedge ref_clk) disable iff (srst)
    q.busy && (q.state == touch_scan_pkg::SCAN_AUTO) |-> mem_to_scanner)
    else $error("Scanner lost memory during auto scan");
  owner_return_a: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(q.busy) |-> (mem_to_scanner == q.owner))
    else $error("Memory not returned to owner bit");
  owner_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
    !q.busy |-> (mem_to_scanner == q.owner))
    else $error("Memory owner mismatch when idle");
  sw_set_a: assert property (@(posedge ref_clk) disable iff (srst)
    wr_ctl && wbyte[touch_scan_pkg::CTL_OVF] && !end_event
    |=> q.irq_stat[touch_scan_pkg::IRQ_MODULE] == $past(q.irq_stat[touch_scan_pkg::IRQ_MODULE]))
    else $error("Software flag set touched the interrupt flag");
  no_self_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    q.ovf_flag && !wr_ctl |=> q.ovf_flag)
    else $error("Overflow flag cleared by hardware");
  mid_overflow_a: assert property (@(posedge ref_clk) disable iff (srst)
    mid_event && !wr_ctl && !q.ovf_flag |=> !q.ovf_flag && (q.func_cnt == touch_scan_pkg::COUNT_ZERO) && q.busy)
    else $error("Mid scan overflow handled wrongly");
  auto_done_a: assert property (@(posedge ref_clk) disable iff (srst)
    end_event && (q.state == touch_scan_pkg::SCAN_AUTO) && !wr_ctl
    |=> q.ovf_flag && q.irq_stat[touch_scan_pkg::IRQ_MODULE] && !q.busy)
    else $error("Auto scan end did not raise flags");
  manual_done_a: assert property (@(posedge ref_clk) disable iff (srst)
    scan_event && (q.state == touch_scan_pkg::SCAN_MANUAL) && !wr_ctl
    |=> q.ovf_flag && q.irq_stat[touch_scan_pkg::IRQ_MODULE] && !q.busy ##1 !osc_enable)
    else $error("Manual overflow did not stop the scan");
  start_run_a: assert property (@(posedge ref_clk) disable iff (srst)
    start_rise |=> q.busy && (q.state == (wbyte[touch_scan_pkg::CTL_MODE] ? touch_scan_pkg::SCAN_MANUAL
                                         : touch_scan_pkg::SCAN_AUTO)) ##1 osc_enable)
    else $error("Start did not begin the scan");
  stop_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    !q.start && !$past(q.start) |-> (q.func_cnt == touch_scan_pkg::COUNT_ZERO) && !q.busy)
    else $error("Counters not cleared while stopped");

  auto_end_c: cover property (@(posedge ref_clk) disable iff (srst)
    end_event && (q.state == touch_scan_pkg::SCAN_AUTO));
  manual_end_c: cover property (@(posedge ref_clk) disable iff (srst)
    end_event && (q.state == touch_scan_pkg::SCAN_MANUAL));
  mid_c: cover property (@(posedge ref_clk) disable iff (srst) mid_event);
  irq_c: cover property (@(posedge ref_clk) disable iff (srst) $rose(irq));

endmodule : touch_key_scan_timing

// *** touch_osc_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Touch and slot oscillators
// ----------------------------------------------------------------
// Pins stand low while disabled; slow halves the slot clock rate.
module touch_osc_model (
  input wire logic ref_clk,
  input wire logic osc_enable,
  input wire logic slow,
  output logic slot_clk,
  output logic [touch_scan_pkg::NUM_MODULES-1:0] key_osc
);
  logic [3:0] div;
  initial begin
    div = 4'h0;
    slot_clk = 1'b0;
    key_osc = 3'h0;
  end
  always @(posedge ref_clk) begin
    div <= osc_enable ? div + 4'h1 : 4'h0;
    slot_clk <= osc_enable & (slow ? div[3] : div[2]);
    key_osc <= osc_enable ? div[3:1] : 3'h0;
  end
endmodule : touch_osc_model

// *** touch_key_scan_timing_tb.sv ***
`timescale 1ns/1ps
module touch_key_scan_timing_tb;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  logic slot_clk, osc_enable, irq, mem_to_scanner;
  logic [touch_scan_pkg::NUM_MODULES-1:0] key_osc;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pre;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] strb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  int failures = 0, tests_run = 0;
  int cyc, exp, dv, f, k;

  touch_key_scan_timing dut (.ref_clk(ref_clk), .srst(srst), .slot_clk(slot_clk), .key_osc(key_osc),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .mem_to_scanner(mem_to_scanner), .osc_enable(osc_enable));
  touch_osc_model osc (.ref_clk(ref_clk), .osc_enable(osc_enable), .slow(slow), .slot_clk(slot_clk),
    .key_osc(key_osc));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  function automatic int slot_cyc(input logic [7:0] p, input int per);
    return (256 - int'(p)) * 32 * per;
  endfunction : slot_cyc

  function automatic logic [31:0] win(input int got, input int e);
    return 32'(got > e - 64 && got < e + 64);
  endfunction : win

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      rs = bresp;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    if (n >= 100) begin
      failures++;
      results();
    end
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready) arvalid <= 1'b0;
      rd = rdata;
      rs = rresp;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    if (n >= 100) begin
      failures++;
      results();
    end
  endtask : rdr

  task automatic wait_osc(input logic lvl);
    cyc = 0;
    while (osc_enable !== lvl && cyc < 20000) begin
      @(posedge ref_clk);
      cyc++;
    end
    if (cyc >= 20000) begin
      failures++;
      results();
    end
  endtask : wait_osc

  task automatic fcnt();
    rdr(8'h0c);
    f = int'(rd[7:0]);
    rdr(8'h10);
    f += int'(rd[7:0]) << 8;
  endtask : fcnt

  initial begin
    void'($urandom(32'h3bc6));
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      rdr(8'(4 * i));
      chk(rd, (i == 2) ? 32'h3 : 32'h0);
      chk(32'(rs), (i == 7) ? 32'h2 : 32'h0);
    end
    wr(8'h40, 32'h1);
    chk(32'(rs), 32'h2);
    pre = 8'($urandom());
    wr(8'h00, {24'h0, pre});
    rdr(8'h00);
    chk(rd, {24'h0, pre});
    // Byte lane 0 disabled: the write must store nothing
    strb <= 4'he;
    wr(8'h00, {24'h0, ~pre});
    strb <= 4'hf;
    chk(32'(rs), 32'h0);
    rdr(8'h00);
    chk(rd, {24'h0, pre});
    wr(8'h04, 32'h80);
    repeat (3) @(posedge ref_clk);
    chk(32'(mem_to_scanner), 32'h1);
    wr(8'h18, 32'h1);
    wr(8'h04, 32'h40);
    repeat (3) @(posedge ref_clk);
    chk(32'(mem_to_scanner), 32'h0);
    rdr(8'h04);
    chk(rd, 32'h40);
    rdr(8'h14);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    // Manual scan on module 0 slot counter, random divider
    pre = 8'hfc + 8'($urandom_range(2));
    dv = $urandom_range(3);
    wr(8'h00, {24'h0, pre});
    wr(8'h08, 32'h13 | (32'(dv) << 2));
    wr(8'h04, 32'h22);
    wait_osc(1'b1);
    rdr(8'h04);
    chk(rd & 32'h63, 32'h23);
    wait_osc(1'b0);
    chk(win(cyc, slot_cyc(pre, 8)), 32'h1);
    rdr(8'h04);
    chk(rd & 32'h43, 32'h42);
    rdr(8'h14);
    chk(rd & 32'h1, 32'h1);
    chk(32'(irq), 32'h1);
    fcnt();
    chk(win(f, slot_cyc(pre, 8) >> dv), 32'h1);
    k = f;
    fcnt();
    chk(32'(f), 32'(k));
    for (int m = 0; m < 3; m++) begin
      rdr(8'(32 + 8 * m));
      k = int'(rd);
      rdr(8'(36 + 8 * m));
      chk(32'((k | int'(rd)) != 0), 32'h1);
    end
    wr(8'h14, 32'h1);
    rdr(8'h14);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    wr(8'h04, 32'h02);
    fcnt();
    chk(32'(f), 32'h0);
    rdr(8'h20);
    chk(rd, 32'h0);
    // Auto scans, slow slot clock: owner clear shows scanner priority, then owner set as software should
    slow <= 1'b1;
    for (int o = 0; o < 2; o++) begin
      pre = 8'hfc + 8'($urandom_range(2));
      wr(8'h00, {24'h0, pre});
      wr(8'h08, 32'h3 | (32'($urandom_range(1)) << 4));
      wr(8'h04, 32'h20 | (32'(o) << 7));
      wait_osc(1'b1);
      repeat (2 * slot_cyc(pre, 16)) @(posedge ref_clk);
      rdr(8'h04);
      chk(rd, 32'h21 | (32'(o) << 7));
      chk(32'(mem_to_scanner), 32'h1);
      wait_osc(1'b0);
      chk(win(cyc, 2 * slot_cyc(pre, 16)), 32'h1);
      rdr(8'h04);
      chk(rd & 32'h41, 32'h40);
      rdr(8'h14);
      chk(rd & 32'h1, 32'h1);
      chk(32'(mem_to_scanner), 32'(o));
      fcnt();
      chk(win(f, slot_cyc(pre, 16)), 32'h1);
      wr(8'h14, 32'h1);
      wr(8'h04, 32'(o) << 7);
    end
    results();
  end
endmodule : touch_key_scan_timing_tb
